// ### verilog/prx_defs.svh
// Purpose: register offsets, field positions, masks and reset values of the
//          proximity result and interrupt block
// Assumes: byte-wide register port behind the serial interface
// Notes:   definitions only
`ifndef PRX_DEFS_SVH
`define PRX_DEFS_SVH

// register offsets
`define PRX_ADDR_FLAGS        8'h8c
`define PRX_ADDR_RES_LO       8'h8d
`define PRX_ADDR_RES_HI       8'h8e
`define PRX_ADDR_IRQ_CFG      8'h8f
`define PRX_ADDR_UP_LO        8'h90
`define PRX_ADDR_UP_HI        8'h91
`define PRX_ADDR_LOW_LO       8'h92
`define PRX_ADDR_LOW_HI       8'h93
`define PRX_ADDR_PERSIST      8'h9e

// field positions
`define PRX_FLAGS_NEW_BIT     0
`define PRX_FLAGS_IRQ_BIT     1
`define PRX_RES_SAT_BIT       7
`define PRX_CFG_POL_BIT       2
`define PRX_PERSIST_LSB       4

// writable-bit masks
`define PRX_MASK_HI3          8'h07
`define PRX_MASK_CFG          8'h07
`define PRX_MASK_PERSIST      8'hf0

// reset values
`define PRX_RST_FLAGS         8'h00
`define PRX_RST_CFG           8'h00
`define PRX_RST_UP_LO         8'hff
`define PRX_RST_UP_HI         8'h07
`define PRX_RST_LOW_LO        8'h00
`define PRX_RST_LOW_HI        8'h00
`define PRX_RST_PERSIST       8'h00
`define PRX_RST_RESULT        11'h000

// interrupt mode field value that lets a result drive the pin
`define PRX_MODE_PROX         2'h1

// value of unmapped registers
`define PRX_UNMAPPED_DATA     8'h00

`endif

// ### verilog/prx_pkg.sv
// Purpose: shared types of the proximity result and interrupt block
// Assumes: nothing
// Notes:   constants live in prx_defs.svh
package prx_pkg;

    // 11-bit measurement value
    typedef logic [10:0] prx_result_t;

    // register byte
    typedef logic [7:0] prx_byte_t;

    // interrupt mode field
    typedef enum logic [1:0] {
        PRX_MODE_OFF,
        PRX_MODE_PROXIMITY,
        PRX_MODE_RSVD2,
        PRX_MODE_RSVD3
    } prx_mode_t;

endpackage

// ### verilog/prx_persist.sv
// Purpose: window compare and persistence filter for one result stream
// Assumes: eval_in pulses once per result loaded into the result registers
// Notes:   hit_out holds until the next evaluation
`timescale 1ns/1ps
`default_nettype none

module prx_persist #(
    parameter int VW = 11,
    parameter int PW = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // evaluation
    input wire logic eval_in,
    input wire logic [VW-1:0] value_in,
    input wire logic [VW-1:0] upper_in,
    input wire logic [VW-1:0] lower_in,
    input wire logic [PW-1:0] persist_in,
    // result
    output logic hit_out
);

    logic outside;
    logic [PW:0] run_q;
    logic [PW:0] run_d;
    logic [PW:0] need;

    // outside the window between the limits
    assign outside = (value_in > upper_in) || (value_in < lower_in); // R15
    // setting n asks for n+1 consecutive results
    assign need = {1'b0, persist_in} + {{PW{1'b0}}, 1'b1}; // R18

    always_comb
    begin
        run_d = run_q;
        if (outside && (run_q < need))
        begin
            run_d = run_q + {{PW{1'b0}}, 1'b1};
        end
        else if (!outside)
        begin
            run_d = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // run counter and hit flag
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            run_q <= '0;
        end
        else if (eval_in)
        begin
            run_q <= run_d; // R18
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            hit_out <= 1'b0;
        end
        else if (eval_in)
        begin
            hit_out <= outside && (run_d >= need); // R4
        end
    end

endmodule

`default_nettype wire

// ### verilog/prx_result_irq.sv
// Purpose: result holding, status flags, thresholds and interrupt pin of a
//          proximity sensor
// Assumes: the serial front end gives byte register reads and writes and a
//          level that is high for the whole of a serial read transaction
// Notes:   interrupt pin is open drain; the level driven is always low
//
// What this block does
// R1 - finished measurement sets the new-data flag
// R2 - reading result registers clears new-data flag
// R3 - status register: interrupt bit1, new-data bit0
// R4 - out-of-window result sets interrupt status
// R5 - 11-bit result: low byte, high 3 bits
// R6 - result registers frozen during serial read
// R7 - result during read shadowed, loaded after read
// R8 - saturation flag in high result bit 7
// R9 - saturation reads zero unless enabled
// R10 - mode 00 keeps interrupt pin released
// R11 - status flags update even with pin disabled
// R12 - mode 1 drives pin when criterion met
// R13 - polarity bit 2 selects active level
// R14 - host configures interrupt before active mode
// R15 - criterion true only outside threshold window
// R16 - thresholds use the result's 11-bit layout
// R17 - upper resets full scale, lower zero
// R18 - persistence needs n+1 consecutive outside results
// R19 - reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "prx_defs.svh"

module prx_result_irq #(
    parameter int VW = 11,
    parameter int PW = 4
) (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    // register port from the serial front end
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_RD_IN,
    input wire logic READ_BUSY_IN,
    output logic [7:0] REG_RDATA_OUT,
    // measurement engine
    input wire logic MEAS_DONE_IN,
    input wire logic [VW-1:0] MEAS_VALUE_IN,
    input wire logic MEAS_SAT_IN,
    // proximity control
    input wire logic SAT_IND_EN_IN,
    // interrupt pin, open drain
    output logic INT_OUT,
    output logic INT_OE_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    prx_pkg::prx_result_t result_q;
    prx_pkg::prx_result_t shadow_q;
    prx_pkg::prx_result_t upper_lim;
    prx_pkg::prx_result_t lower_lim;
    prx_pkg::prx_byte_t up_lo_q;
    prx_pkg::prx_byte_t up_hi_q;
    prx_pkg::prx_byte_t low_lo_q;
    prx_pkg::prx_byte_t low_hi_q;
    prx_pkg::prx_byte_t cfg_q;
    prx_pkg::prx_byte_t persist_q;
    prx_pkg::prx_byte_t rdata_d;
    prx_pkg::prx_mode_t mode;
    logic sat_q;
    logic shadow_sat_q;
    logic shadow_full_q;
    logic new_data_q;
    logic irq_hit;
    logic load_direct;
    logic load_shadow;
    logic load_any;
    logic rd_result;
    logic wr_up_lo;
    logic wr_up_hi;
    logic wr_low_lo;
    logic wr_low_hi;
    logic wr_cfg;
    logic wr_persist;
    logic pin_active;
    logic int_oe_d;

    ////////////////////////////////////////////////////////////////////////
    // result loading
    // a result goes straight in only while no serial read is running
    assign load_direct = MEAS_DONE_IN && !READ_BUSY_IN; // R6
    // a shadowed result moves in as soon as the read is over, unless a new result arrives in that cycle
    assign load_shadow = shadow_full_q && !READ_BUSY_IN && !MEAS_DONE_IN; // R7
    assign load_any = load_direct || load_shadow;

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            shadow_q <= `PRX_RST_RESULT;
        end
        else if (MEAS_DONE_IN && READ_BUSY_IN)
        begin
            shadow_q <= MEAS_VALUE_IN; // R7
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            shadow_sat_q <= 1'b0;
        end
        else if (MEAS_DONE_IN && READ_BUSY_IN)
        begin
            shadow_sat_q <= MEAS_SAT_IN; // R8
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            shadow_full_q <= 1'b0;
        end
        else if (MEAS_DONE_IN && READ_BUSY_IN)
        begin
            shadow_full_q <= 1'b1; // R7
        end
        else if (load_any)
        begin
            shadow_full_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            result_q <= `PRX_RST_RESULT;
        end
        else if (load_direct)
        begin
            result_q <= MEAS_VALUE_IN; // R5
        end
        else if (load_shadow)
        begin
            result_q <= shadow_q; // R7
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            sat_q <= 1'b0;
        end
        else if (load_direct)
        begin
            sat_q <= MEAS_SAT_IN; // R8
        end
        else if (load_shadow)
        begin
            sat_q <= shadow_sat_q; // R8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // new-data flag
    assign rd_result = REG_RD_IN &&
        ((REG_ADDR_IN == `PRX_ADDR_RES_LO) || (REG_ADDR_IN == `PRX_ADDR_RES_HI));

    // a load in the same cycle as a read wins over the clear
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            new_data_q <= 1'b0;
        end
        else if (load_any)
        begin
            new_data_q <= 1'b1; // R1 R11
        end
        else if (rd_result)
        begin
            new_data_q <= 1'b0; // R2
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // threshold compare and persistence
    assign upper_lim = {up_hi_q[2:0], up_lo_q}; // R16
    assign lower_lim = {low_hi_q[2:0], low_lo_q}; // R16

    prx_persist #(
        .VW(VW),
        .PW(PW)
    ) u_persist (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RST_N_IN),
        .eval_in(load_any),
        .value_in(load_direct ? MEAS_VALUE_IN : shadow_q),
        .upper_in(upper_lim),
        .lower_in(lower_lim),
        .persist_in(persist_q[7:4]),
        .hit_out(irq_hit)
    ); // R4 R11 R15 R18

    ////////////////////////////////////////////////////////////////////////
    // register writes
    assign wr_up_lo = REG_WR_IN && (REG_ADDR_IN == `PRX_ADDR_UP_LO);
    assign wr_up_hi = REG_WR_IN && (REG_ADDR_IN == `PRX_ADDR_UP_HI);
    assign wr_low_lo = REG_WR_IN && (REG_ADDR_IN == `PRX_ADDR_LOW_LO);
    assign wr_low_hi = REG_WR_IN && (REG_ADDR_IN == `PRX_ADDR_LOW_HI);
    assign wr_cfg = REG_WR_IN && (REG_ADDR_IN == `PRX_ADDR_IRQ_CFG);
    assign wr_persist = REG_WR_IN && (REG_ADDR_IN == `PRX_ADDR_PERSIST);

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            up_lo_q <= `PRX_RST_UP_LO; // R17
        end
        else if (wr_up_lo)
        begin
            up_lo_q <= REG_WDATA_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            up_hi_q <= `PRX_RST_UP_HI; // R17
        end
        else if (wr_up_hi)
        begin
            up_hi_q <= REG_WDATA_IN & `PRX_MASK_HI3; // R19
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            low_lo_q <= `PRX_RST_LOW_LO; // R17
        end
        else if (wr_low_lo)
        begin
            low_lo_q <= REG_WDATA_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            low_hi_q <= `PRX_RST_LOW_HI; // R17
        end
        else if (wr_low_hi)
        begin
            low_hi_q <= REG_WDATA_IN & `PRX_MASK_HI3; // R19
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            cfg_q <= `PRX_RST_CFG; // R13
        end
        else if (wr_cfg)
        begin
            cfg_q <= REG_WDATA_IN & `PRX_MASK_CFG; // R19
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            persist_q <= `PRX_RST_PERSIST;
        end
        else if (wr_persist)
        begin
            persist_q <= REG_WDATA_IN & `PRX_MASK_PERSIST; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads
    always_comb
    begin
        rdata_d = `PRX_UNMAPPED_DATA;
        case (REG_ADDR_IN)
            `PRX_ADDR_FLAGS:
            begin
                rdata_d[`PRX_FLAGS_IRQ_BIT] = irq_hit; // R3
                rdata_d[`PRX_FLAGS_NEW_BIT] = new_data_q; // R3
            end
            `PRX_ADDR_RES_LO:
            begin
                rdata_d = result_q[7:0]; // R5
            end
            `PRX_ADDR_RES_HI:
            begin
                rdata_d[2:0] = result_q[10:8]; // R5
                rdata_d[`PRX_RES_SAT_BIT] = sat_q && SAT_IND_EN_IN; // R8 R9
            end
            `PRX_ADDR_IRQ_CFG:
            begin
                rdata_d = cfg_q;
            end
            `PRX_ADDR_UP_LO:
            begin
                rdata_d = up_lo_q;
            end
            `PRX_ADDR_UP_HI:
            begin
                rdata_d = up_hi_q;
            end
            `PRX_ADDR_LOW_LO:
            begin
                rdata_d = low_lo_q;
            end
            `PRX_ADDR_LOW_HI:
            begin
                rdata_d = low_hi_q;
            end
            `PRX_ADDR_PERSIST:
            begin
                rdata_d = persist_q;
            end
            default:
            begin
                rdata_d = `PRX_UNMAPPED_DATA;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            REG_RDATA_OUT <= `PRX_UNMAPPED_DATA;
        end
        else if (REG_RD_IN)
        begin
            REG_RDATA_OUT <= rdata_d; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pin
    assign mode = prx_pkg::prx_mode_t'(cfg_q[1:0]);

    always_comb
    begin
        pin_active = 1'b0;
        case (mode)
            prx_pkg::PRX_MODE_OFF:
            begin
                pin_active = 1'b0; // R10
            end
            prx_pkg::PRX_MODE_PROXIMITY:
            begin
                pin_active = irq_hit; // R12
            end
            default:
            begin
                pin_active = 1'b0;
            end
        endcase
    end

    // open drain: active low pulls when active, active high pulls when idle
    always_comb
    begin
        int_oe_d = 1'b0;
        if (mode == prx_pkg::PRX_MODE_OFF)
        begin
            int_oe_d = 1'b0; // R10
        end
        else if (mode == prx_pkg::PRX_MODE_PROXIMITY)
        begin
            int_oe_d = pin_active ^ cfg_q[`PRX_CFG_POL_BIT]; // R13
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            INT_OE_OUT <= 1'b0;
        end
        else
        begin
            INT_OE_OUT <= int_oe_d; // R12 R13
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            INT_OUT <= 1'b0;
        end
        else
        begin
            INT_OUT <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### verif/prx_result_irq_checker.sv
// Purpose: port-level checks of the proximity result and interrupt block
// Assumes: ports of prx_result_irq only
// Notes:   mirrors the interrupt config register to judge the pin
`timescale 1ns/1ps
`default_nettype none
`include "prx_defs.svh"

module prx_result_irq_checker #(
    parameter int VW = 11,
    parameter int PW = 4
) (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    // register port
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_RD_IN,
    input wire logic READ_BUSY_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    // measurement and control
    input wire logic MEAS_DONE_IN,
    input wire logic [VW-1:0] MEAS_VALUE_IN,
    input wire logic MEAS_SAT_IN,
    input wire logic SAT_IND_EN_IN,
    // interrupt pin
    input wire logic INT_OUT,
    input wire logic INT_OE_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    logic [2:0] cfg_q;

    // mirror of polarity and mode
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            cfg_q <= 3'h0;
        end
        else if (REG_WR_IN && REG_ADDR_IN == `PRX_ADDR_IRQ_CFG)
        begin
            cfg_q <= REG_WDATA_IN[2:0];
        end
    end

    sequence s_rd(logic [7:0] a);
        REG_RD_IN && REG_ADDR_IN == a;
    endsequence

    sequence s_brd(logic [7:0] a);
        REG_RD_IN && REG_ADDR_IN == a && READ_BUSY_IN;
    endsequence

    sequence s_load;
        MEAS_DONE_IN && !READ_BUSY_IN ##1 !REG_RD_IN [*2];
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    AST_NEW_SET: assert property (s_load ##1 s_rd(`PRX_ADDR_FLAGS) |=> REG_RDATA_OUT[0])
        else $error("new-data flag not set after a load");
    AST_NEW_CLR: assert property (s_brd(`PRX_ADDR_RES_HI) ##1 READ_BUSY_IN ##1
        s_brd(`PRX_ADDR_FLAGS) |=> !REG_RDATA_OUT[0])
        else $error("new-data flag not cleared by a result read");
    AST_FLAGS_RSV: assert property (s_rd(`PRX_ADDR_FLAGS) |=> REG_RDATA_OUT[7:2] == 6'h00)
        else $error("status reserved bits not zero");
    AST_FROZEN: assert property (s_brd(`PRX_ADDR_RES_LO) ##1 s_brd(`PRX_ADDR_RES_LO)
        |=> $stable(REG_RDATA_OUT))
        else $error("result changed during a read");
    AST_SAT_GATE: assert property (s_rd(`PRX_ADDR_RES_HI) ##0 !SAT_IND_EN_IN
        |=> !REG_RDATA_OUT[7])
        else $error("saturation shown while disabled");
    AST_MODE_OFF: assert property ((cfg_q[1:0] != `PRX_MODE_PROX) [*2] |-> !INT_OE_OUT)
        else $error("pin driven with mode off");
    AST_POL_LOW: assert property (cfg_q == 3'h1 && REG_RD_IN &&
        REG_ADDR_IN == `PRX_ADDR_FLAGS |=> REG_RDATA_OUT[1] == INT_OE_OUT)
        else $error("active-low pin disagrees with status");
    AST_POL_HIGH: assert property (cfg_q == 3'h5 && REG_RD_IN &&
        REG_ADDR_IN == `PRX_ADDR_FLAGS |=> REG_RDATA_OUT[1] != INT_OE_OUT)
        else $error("active-high pin disagrees with status");
    AST_HI_RSV: assert property (s_rd(`PRX_ADDR_RES_HI) |=> REG_RDATA_OUT[6:3] == 4'h0)
        else $error("result high reserved bits not zero");
endmodule

bind prx_result_irq prx_result_irq_checker #(.VW(VW), .PW(PW)) prx_result_irq_checker_i (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WR_IN(REG_WR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RD_IN(REG_RD_IN),
    .READ_BUSY_IN(READ_BUSY_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .MEAS_DONE_IN(MEAS_DONE_IN),
    .MEAS_VALUE_IN(MEAS_VALUE_IN), .MEAS_SAT_IN(MEAS_SAT_IN), .SAT_IND_EN_IN(SAT_IND_EN_IN),
    .INT_OUT(INT_OUT), .INT_OE_OUT(INT_OE_OUT)
);
`default_nettype wire

// ### verif/prx_host_model.sv
// Purpose: host side of the byte register port behind the serial link
// Assumes: drives at the falling edge, one-cycle strobes except the two-cycle read strobe of rd_lo2
// Notes:   write data is inverted once released
`timescale 1ns/1ps
`default_nettype none
`include "prx_defs.svh"

module prx_host_model (
    // clock
    input wire logic clk_in,
    // register port
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic [7:0] wdata_out,
    output logic rd_out,
    output logic busy_out,
    input wire logic [7:0] rdata_in
);
    initial
    begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
        rd_out = 1'b0;
        busy_out = 1'b0;
    end

    // one byte write, thresholds in the result layout
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        d = rdata_in;
    endtask

    // two back-to-back low result reads
    task automatic rd_lo2(output logic [7:0] d0, output logic [7:0] d1);
        @(negedge clk_in);
        addr_out = `PRX_ADDR_RES_LO;
        rd_out = 1'b1;
        @(negedge clk_in);
        d0 = rdata_in;
        @(negedge clk_in);
        rd_out = 1'b0;
        d1 = rdata_in;
    endtask

    task automatic busy(input logic b);
        @(negedge clk_in);
        busy_out = b;
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: self-checking bench of the proximity result and interrupt block
// Assumes: 50 MHz clock, inputs driven at the falling edge
// Notes:   register access through the host model tasks
`timescale 1ns/1ps
`default_nettype none
`include "prx_defs.svh"

module tb_top;
    logic clk;
    logic rst_n;
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic rd;
    logic busy;
    logic [7:0] rdata;
    logic meas_done;
    logic [10:0] meas_value;
    logic meas_sat;
    logic sat_en;
    logic int_out;
    logic int_oe;
    logic [7:0] d;
    logic [7:0] d1;
    int errors;
    int check_count;
    logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h07, 8'h00, 8'h00};
    logic [10:0] vtab [6] = '{11'h10f, 11'h110, 11'h534, 11'h535, 11'h7ff, 11'h200};
    logic htab [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [10:0] ptab [5] = '{11'h200, 11'h7ff, 11'h7ff, 11'h7ff, 11'h200};
    logic pexp [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

    prx_result_irq prx_result_irq_i (
        .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WR_IN(wr),
        .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .READ_BUSY_IN(busy), .REG_RDATA_OUT(rdata),
        .MEAS_DONE_IN(meas_done), .MEAS_VALUE_IN(meas_value), .MEAS_SAT_IN(meas_sat),
        .SAT_IND_EN_IN(sat_en), .INT_OUT(int_out), .INT_OE_OUT(int_oe)
    );

    prx_host_model prx_host_model_i (
        .clk_in(clk), .addr_out(addr), .wr_out(wr), .wdata_out(wdata), .rd_out(rd),
        .busy_out(busy), .rdata_in(rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        prx_host_model_i.rd(a, d);
        chk(d, e);
    endtask

    task automatic meas(input logic [10:0] v, input logic s);
        @(negedge clk);
        meas_value = v;
        meas_sat = s;
        meas_done = 1'b1;
        @(negedge clk);
        meas_done = 1'b0;
        meas_value = ~v;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        errors = 0;
        check_count = 0;
        rst_n = 1'b0;
        meas_done = 1'b0;
        meas_value = 11'h000;
        meas_sat = 1'b0;
        sat_en = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        foreach (rst_tab[i])
        begin
            rchk(`PRX_ADDR_FLAGS + 8'(i), rst_tab[i]);
        end
        rchk(`PRX_ADDR_PERSIST, 8'h00);
        rchk(8'ha0, 8'h00);
        $display("test reset done");
        prx_host_model_i.wr(`PRX_ADDR_UP_LO, 8'h34);
        prx_host_model_i.wr(`PRX_ADDR_UP_HI, 8'hfd);
        prx_host_model_i.wr(`PRX_ADDR_LOW_LO, 8'h10);
        prx_host_model_i.wr(`PRX_ADDR_LOW_HI, 8'h01);
        rchk(`PRX_ADDR_UP_HI, 8'h05);
        rchk(`PRX_ADDR_UP_LO, 8'h34);
        rchk(`PRX_ADDR_LOW_HI, 8'h01);
        prx_host_model_i.wr(`PRX_ADDR_IRQ_CFG, 8'hff);
        rchk(`PRX_ADDR_IRQ_CFG, 8'h07);
        prx_host_model_i.wr(`PRX_ADDR_RES_LO, 8'haa);
        rchk(`PRX_ADDR_RES_LO, 8'h00);
        prx_host_model_i.wr(`PRX_ADDR_IRQ_CFG, 8'h01);
        $display("test config done");
        foreach (vtab[i])
        begin
            meas(vtab[i], 1'b0);
            prx_host_model_i.busy(1'b1);
            rchk(`PRX_ADDR_FLAGS, {6'h00, htab[i], 1'b1});
            rchk(`PRX_ADDR_RES_LO, vtab[i][7:0]);
            rchk(`PRX_ADDR_RES_HI, {5'h00, vtab[i][10:8]});
            rchk(`PRX_ADDR_FLAGS, {6'h00, htab[i], 1'b0});
            prx_host_model_i.busy(1'b0);
            chk({6'h00, int_out, int_oe}, {7'h00, htab[i]});
        end
        $display("test window done");
        prx_host_model_i.wr(`PRX_ADDR_IRQ_CFG, 8'h05);
        rchk(`PRX_ADDR_FLAGS, 8'h00);
        chk({7'h00, int_oe}, 8'h01);
        meas(11'h7ff, 1'b0);
        rchk(`PRX_ADDR_FLAGS, 8'h03);
        chk({6'h00, int_out, int_oe}, 8'h00);
        prx_host_model_i.wr(`PRX_ADDR_IRQ_CFG, 8'h00);
        meas(11'h7ff, 1'b0);
        repeat (2) @(negedge clk);
        chk({7'h00, int_oe}, 8'h00);
        rchk(`PRX_ADDR_FLAGS, 8'h03);
        $display("test polarity done");
        prx_host_model_i.busy(1'b1);
        fork
            meas(11'h0aa, 1'b0);
            prx_host_model_i.rd_lo2(d, d1);
        join
        chk(d, 8'hff);
        chk(d1, 8'hff);
        prx_host_model_i.busy(1'b0);
        repeat (2) @(negedge clk);
        rchk(`PRX_ADDR_FLAGS, 8'h03);
        rchk(`PRX_ADDR_RES_LO, 8'haa);
        rchk(`PRX_ADDR_RES_HI, 8'h00);
        $display("test lock done");
        meas(11'h001, 1'b1);
        rchk(`PRX_ADDR_RES_HI, 8'h00);
        @(negedge clk);
        sat_en = 1'b1;
        rchk(`PRX_ADDR_RES_HI, 8'h80);
        meas(11'h001, 1'b0);
        rchk(`PRX_ADDR_RES_HI, 8'h00);
        $display("test saturation done");
        prx_host_model_i.wr(`PRX_ADDR_PERSIST, 8'h2f);
        rchk(`PRX_ADDR_PERSIST, 8'h20);
        foreach (ptab[i])
        begin
            meas(ptab[i], 1'b0);
            rchk(`PRX_ADDR_FLAGS, {6'h00, pexp[i], 1'b1});
        end
        $display("test persistence done");
        summarize();
    end
endmodule
`default_nettype wire
